/* File: glm_cfg.svh */
// glm_cfg.svh: offsets, field positions, codes and counts of the matrix driver
// assumes: included by bare name from the memory, core, checker and bench files of the block; the package does not include it
`ifndef GLM_CFG_SVH
`define GLM_CFG_SVH
`define GLM_COLS       128
`define GLM_BANKS      6
`define GLM_X_LAST     7'h7f
`define GLM_X_ZERO     7'h00
`define GLM_Y_GFX_LAST 3'h4
`define GLM_Y_ICON     3'h5
`define GLM_ROW_B4     6'h20
`define GLM_ROW_ICON   6'h21
`define GLM_ROW_ZERO   6'h00
`define GLM_ROW_ONE    6'h01
`define GLM_ROW_STEP   6'h02
`define GLM_MASK_B4    8'h01
`define GLM_MASK_B5    8'h10
`define GLM_MASK_ALL   8'hff
`define GLM_BIT_B4     3'h0
`define GLM_BIT_B5     3'h4
`define GLM_MUX_17     2'h0
`define GLM_MUX_26     2'h2
`define GLM_MUX_34     2'h1
`define GLM_ROWS_17    6'h11
`define GLM_ROWS_26    6'h1a
`define GLM_ROWS_34    6'h22
`define GLM_BYTE_BITS  4'h8
`define GLM_CB_CO      7
`define GLM_CB_RS      6
`define GLM_M_3        8'hf8
`define GLM_M_2        8'hfc
`define GLM_M_X        8'h80
`define GLM_OP_FUNC    8'h20
`define GLM_OP_DISP    8'h08
`define GLM_OP_MUX     8'h04
`define GLM_OP_BIAS    8'h10
`define GLM_OP_HVGEN   8'h30
`define GLM_OP_TEMP    8'h60
`define GLM_OP_SETY    8'h40
`define GLM_OP_SETX    8'h80
`define GLM_FB_PD      2
`define GLM_FB_V       1
`define GLM_DB_D       2
`define GLM_DB_IM      1
`define GLM_DB_E       0
`define GLM_HB_HVE     2
`endif

/* File: glm_pkg.sv */
// glm_pkg.sv: types shared by the matrix driver files
// assumes: nothing beyond the tool's package support
`default_nettype none
package glm_pkg;
  // serial receiver states
  typedef enum logic [1:0] {
    GLM_IDLE = 2'b00,
    GLM_BITS = 2'b01,
    GLM_ACK  = 2'b10,
    GLM_SKIP = 2'b11
  } glm_state_t;
  // meaning of the byte being received
  typedef enum logic [1:0] {
    GLM_K_ADDR = 2'b00,
    GLM_K_CTRL = 2'b01,
    GLM_K_DATA = 2'b10
  } glm_kind_t;
  // software settings
  typedef struct packed {
    logic       power_down_bit;
    logic       vertical;
    logic       disp_d;
    logic       disp_e;
    logic       icon_only_bit;
    logic [2:0] bias;
    logic [1:0] mux;
    logic [2:0] temp;
    logic       multiplier_enable_bit;
    logic [1:0] mult_factor;
  } glm_cfg_t;
endpackage : glm_pkg
`default_nettype wire

/* File: glm_ram.sv */
// glm_ram.sv: display memory, one write port with bit mask, one registered read port
// assumes: same clock and enable as the driver core
`include "glm_cfg.svh"
`default_nettype none
module glm_ram #(
  parameter int AW    = 10,
  parameter int DW    = 8,
  parameter int DEPTH = `GLM_BANKS * `GLM_COLS
) (
  input  wire logic          sys_clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [DW-1:0] wmask,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // read first
  // a read of the location being written returns the old byte whole
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      rdata <= mem[raddr];
      if (we) begin
        mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
      end
    end
  end
endmodule : glm_ram
`default_nettype wire

/* File: glm_driver.sv */
// glm_driver.sv: core of the dot matrix driver: serial receiver, command decoder,
// write pointer, display memory and refresh sequencer
// assumes: pins arrive asynchronous; rst synchronous; tick spacing above 130 cycles
`include "glm_cfg.svh"
`default_nettype none
module glm_driver #(
  parameter logic [6:0]  SLAVE_ADDR = 7'h3c,
  parameter logic [15:0] OSC_DIV    = 16'h0100,
  parameter logic [15:0] EXT_IDLE   = 16'h1000
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  input  wire logic             reset_source_strap,
  input  wire logic             external_reset_input,
  input  wire logic             por_detect,
  input  wire logic             clock_source_input,
  output logic                  ack_output_pin,
  output logic                  ack_output_pin_oe,
  output glm_pkg::glm_cfg_t     cfg_out,
  output logic [33:0]           row_outputs,
  output logic [`GLM_COLS-1:0]  column_outputs
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic       scl_d;
  logic       sda_d;
  logic       ext_d;
  logic       reset_all;
  // five pins through two flops each
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= 6'h03;
      sync_b <= 6'h03;
    end else if (ce) begin
      sync_a <= {1'b0, clock_source_input, por_detect, external_reset_input,
                 sda_in, scl_in};
      sync_b <= sync_a;
    end
  end
  // previous values for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      ext_d <= 1'b0;
    end else if (ce) begin
      scl_d <= sync_b[0];
      sda_d <= sync_b[1];
      ext_d <= sync_b[4];
    end
  end
  assign reset_all = rst | (reset_source_strap ? sync_b[3] : sync_b[2]);

  // ************************************************************
  // serial receiver
  // ************************************************************
  glm_pkg::glm_state_t state;
  glm_pkg::glm_kind_t  kind;
  logic [7:0] shreg;
  logic [3:0] bcnt;
  logic       rs;
  logic       co;
  logic       start_c, stop_c, rise_c, fall_c, done_c, accept_c, wr_c, cmd_c;
  assign start_c  = sync_b[0] & scl_d & sda_d & ~sync_b[1];
  assign stop_c   = sync_b[0] & scl_d & ~sda_d & sync_b[1];
  assign rise_c   = sync_b[0] & ~scl_d;
  assign fall_c   = ~sync_b[0] & scl_d;
  assign done_c   = (state == glm_pkg::GLM_BITS) & fall_c & (bcnt == `GLM_BYTE_BITS);
  assign accept_c = (kind != glm_pkg::GLM_K_ADDR) |
                    ((shreg[7:1] == SLAVE_ADDR) & ~shreg[0]);
  assign wr_c     = done_c & (kind == glm_pkg::GLM_K_DATA) & rs;
  assign cmd_c    = done_c & (kind == glm_pkg::GLM_K_DATA) & ~rs;

  // receive only
  // byte framing; scl is never driven, only sampled
  always_ff @(posedge sys_clk) begin
    if (reset_all) begin
      state <= glm_pkg::GLM_IDLE;
      bcnt  <= 4'h0;
      shreg <= 8'h00;
    end else if (ce) begin
      if (start_c) begin
        state <= glm_pkg::GLM_BITS;
        bcnt  <= 4'h0;
      end else if (stop_c) begin
        state <= glm_pkg::GLM_IDLE;
      end else begin
        unique case (state)
          glm_pkg::GLM_IDLE: begin
            bcnt <= 4'h0;
          end
          glm_pkg::GLM_BITS: begin
            if (rise_c && bcnt != `GLM_BYTE_BITS) begin
              shreg <= {shreg[6:0], sync_b[1]};
              bcnt  <= bcnt + 4'h1;
            end else if (done_c) begin
              state <= accept_c ? glm_pkg::GLM_ACK : glm_pkg::GLM_SKIP;
            end
          end
          glm_pkg::GLM_ACK: begin
            if (fall_c) begin
              state <= glm_pkg::GLM_BITS;
              bcnt  <= 4'h0;
            end
          end
          glm_pkg::GLM_SKIP: begin
            bcnt <= 4'h0;
          end
        endcase
      end
    end
  end
  // byte meaning and data or command selection
  always_ff @(posedge sys_clk) begin
    if (reset_all) begin
      kind <= glm_pkg::GLM_K_ADDR;
      rs   <= 1'b0;
      co   <= 1'b0;
    end else if (ce) begin
      if (start_c) begin
        kind <= glm_pkg::GLM_K_ADDR;
      end else if (done_c && accept_c) begin
        unique case (kind)
          glm_pkg::GLM_K_ADDR: kind <= glm_pkg::GLM_K_CTRL;
          glm_pkg::GLM_K_CTRL: begin
            rs   <= shreg[`GLM_CB_RS];
            co   <= shreg[`GLM_CB_CO];
            kind <= glm_pkg::GLM_K_DATA;
          end
          glm_pkg::GLM_K_DATA: kind <= co ? glm_pkg::GLM_K_CTRL : glm_pkg::GLM_K_DATA;
          default: kind <= glm_pkg::GLM_K_ADDR;
        endcase
      end
    end
  end
  // separate ack pin
  // ack pulls low for the ninth clock only
  assign ack_output_pin = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (reset_all) begin
      ack_output_pin_oe <= 1'b0;
    end else if (ce) begin
      ack_output_pin_oe <= (state == glm_pkg::GLM_ACK) | (done_c & accept_c);
    end
  end

  // ************************************************************
  // command decoder and settings
  // ************************************************************
  function automatic logic is_op(input logic [7:0] b, input logic [7:0] m,
                                 input logic [7:0] v);
    is_op = (b & m) == v;
  endfunction : is_op

  glm_pkg::glm_cfg_t cfg;
  logic [6:0] wx;
  logic [2:0] wy;
  always_ff @(posedge sys_clk) begin
    if (reset_all) begin
      cfg <= '0;
      cfg.power_down_bit <= 1'b1;
    end else if (ce && cmd_c) begin
      if (is_op(shreg, `GLM_M_3, `GLM_OP_FUNC)) begin
        cfg.power_down_bit <= shreg[`GLM_FB_PD];
        cfg.vertical       <= shreg[`GLM_FB_V];
      end
      if (is_op(shreg, `GLM_M_3, `GLM_OP_DISP)) begin
        cfg.disp_d        <= shreg[`GLM_DB_D];
        cfg.icon_only_bit <= shreg[`GLM_DB_IM];
        cfg.disp_e        <= shreg[`GLM_DB_E];
      end
      if (is_op(shreg, `GLM_M_2, `GLM_OP_MUX)) cfg.mux <= shreg[1:0];
      if (is_op(shreg, `GLM_M_3, `GLM_OP_BIAS)) cfg.bias <= shreg[2:0];
      if (is_op(shreg, `GLM_M_3, `GLM_OP_TEMP)) cfg.temp <= shreg[2:0];
      if (is_op(shreg, `GLM_M_3, `GLM_OP_HVGEN)) begin
        cfg.multiplier_enable_bit <= shreg[`GLM_HB_HVE];
        cfg.mult_factor           <= shreg[1:0]; // 0..3 means two to five times
      end
    end
  end
  assign cfg_out = cfg;

  always_ff @(posedge sys_clk) begin
    if (reset_all) begin
      wx <= `GLM_X_ZERO;
      wy <= 3'h0;
    end else if (ce) begin
      if (cmd_c && is_op(shreg, `GLM_M_X, `GLM_OP_SETX)) begin
        wx <= shreg[6:0];
      end else if (cmd_c && is_op(shreg, `GLM_M_3, `GLM_OP_SETY)) begin
        if (shreg[2:0] <= `GLM_Y_ICON) wy <= shreg[2:0];
      end else if (wr_c) begin
        if (wy == `GLM_Y_ICON) begin
          wx <= wx + 7'h01;
        end else if (cfg.vertical) begin
          wy <= (wy == `GLM_Y_GFX_LAST) ? 3'h0 : wy + 3'h1;
          if (wy == `GLM_Y_GFX_LAST) wx <= wx + 7'h01;
        end else begin
          wx <= wx + 7'h01;
          if (wx == `GLM_X_LAST) wy <= (wy == `GLM_Y_GFX_LAST) ? 3'h0 : wy + 3'h1;
        end
      end
    end
  end
  logic [7:0] wmask;
  always_comb begin
    unique case (wy)
      `GLM_Y_GFX_LAST: wmask = `GLM_MASK_B4;
      `GLM_Y_ICON:     wmask = `GLM_MASK_B5;
      default:         wmask = `GLM_MASK_ALL;
    endcase
  end

  // ************************************************************
  // display memory
  // ************************************************************
  logic [9:0] raddr;
  logic [7:0] rdata;
  glm_ram u_ram (
    .sys_clk (sys_clk),
    .ce      (ce),
    .we      (wr_c),
    .waddr   ({wy, wx}),
    .wdata   (shreg),
    .wmask   (wmask),
    .raddr   (raddr),
    .rdata   (rdata)
  );

  // ************************************************************
  // timing and refresh
  // ************************************************************
  logic [15:0] div_cnt;
  logic [15:0] idle_cnt;
  logic        ext_on;
  logic        tick;
  // clock source
  // external clock counts as present while it keeps toggling
  always_ff @(posedge sys_clk) begin
    if (reset_all) begin
      idle_cnt <= 16'h0000;
      ext_on   <= 1'b0;
    end else if (ce) begin
      if (sync_b[4] & ~ext_d) begin
        idle_cnt <= 16'h0000;
        ext_on   <= 1'b1;
      end else if (idle_cnt == EXT_IDLE) begin
        ext_on <= 1'b0;
      end else begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset_all || cfg.power_down_bit) begin
      div_cnt <= 16'h0000;
    end else if (ce) begin
      div_cnt <= (div_cnt == OSC_DIV - 16'h0001) ? 16'h0000 : div_cnt + 16'h0001;
    end
  end
  assign tick = ~cfg.power_down_bit &
                (ext_on ? (sync_b[4] & ~ext_d) : (div_cnt == OSC_DIV - 16'h0001));

  function automatic logic [5:0] row_count(input logic [1:0] m);
    unique case (m)
      `GLM_MUX_26: row_count = `GLM_ROWS_26;
      `GLM_MUX_34: row_count = `GLM_ROWS_34;
      default:     row_count = `GLM_ROWS_17;
    endcase
  endfunction : row_count

  logic [5:0] frow;
  logic [5:0] drow;
  logic [5:0] nrow;
  logic [7:0] fcnt;
  logic       rvalid;
  logic [6:0] rcol;
  logic [2:0] fbit;
  logic [`GLM_COLS-1:0] shadow;
  logic [`GLM_COLS-1:0] latch;
  always_comb begin
    if (cfg.icon_only_bit) nrow = `GLM_ROW_ICON;
    else if (frow + `GLM_ROW_STEP < row_count(cfg.mux)) nrow = frow + `GLM_ROW_STEP;
    else nrow = frow[0] ? `GLM_ROW_ZERO : `GLM_ROW_ONE;
  end
  // bank and bit of the row being fetched
  always_comb begin
    raddr = {frow[5:3], fcnt[6:0]};
    fbit  = frow[2:0];
    if (frow == `GLM_ROW_B4) begin
      raddr = {`GLM_Y_GFX_LAST, fcnt[6:0]};
      fbit  = `GLM_BIT_B4;
    end else if (frow == `GLM_ROW_ICON) begin
      raddr = {`GLM_Y_ICON, fcnt[6:0]};
      fbit  = `GLM_BIT_B5;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset_all || cfg.power_down_bit) begin
      frow   <= `GLM_ROW_ZERO;
      drow   <= `GLM_ROW_ZERO;
      fcnt   <= 8'h00;
      rvalid <= 1'b0;
      rcol   <= 7'h00;
      latch  <= '0;
    end else if (ce) begin
      rvalid <= ~fcnt[7];
      rcol   <= fcnt[6:0];
      if (tick) begin
        latch <= shadow;
        drow  <= frow;
        frow  <= nrow;
        fcnt  <= 8'h00;
      end else if (!fcnt[7]) begin
        fcnt <= fcnt + 8'h01;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (ce && rvalid) begin
      shadow[rcol] <= rdata[fbit];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset_all || cfg.power_down_bit) begin
      row_outputs    <= '0;
      column_outputs <= '0;
    end else if (ce) begin
      row_outputs       <= '0;
      row_outputs[drow] <= 1'b1;
      unique case ({cfg.disp_d, cfg.disp_e})
        2'h2:    column_outputs <= latch;
        2'h1:    column_outputs <= '1;
        2'h3:    column_outputs <= ~latch;
        default: column_outputs <= '0;
      endcase
    end
  end
endmodule : glm_driver
`default_nettype wire

/* File: glm_driver_sva.sv */
// glm_driver_sva.sv: port checker for the matrix driver core
// assumes: bound into glm_driver; one clock, rst synchronous
`include "glm_cfg.svh"
`default_nettype none
module glm_chk (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 ack_output_pin,
  input wire logic                 ack_output_pin_oe,
  input wire glm_pkg::glm_cfg_t    cfg_out,
  input wire logic [33:0]          row_outputs,
  input wire logic [`GLM_COLS-1:0] column_outputs
);
  // ****
  // helpers
  // ****
  localparam int MIN_GAP = 130;
  logic [7:0] gap;
  // cycles since the row select last moved
  always_ff @(posedge sys_clk) begin
    if (rst)
      gap <= 8'h00;
    else if ($changed(row_outputs))
      gap <= 8'h00;
    else if (gap != 8'hff)
      gap <= gap + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // assertions
  // ****
  // ack pin value
  a_ack_pin_low: assert property (ack_output_pin == 1'b0)
    else $error("ack pin not low");
  a_ack_short: assert property ($rose(ack_output_pin_oe) |->
    ack_output_pin_oe [*4] ##[1:40] !ack_output_pin_oe)
    else $error("ack pulse length wrong");
  a_reset_state: assert property ($fell(rst) |-> cfg_out == 16'h8000 &&
    row_outputs == 34'h0 && column_outputs == '0)
    else $error("state after reset wrong");
  a_pd_dark: assert property (cfg_out.power_down_bit &&
    $past(cfg_out.power_down_bit) |-> row_outputs == 34'h0 && column_outputs == '0)
    else $error("outputs driven in power down");
  a_row_onehot: assert property ($onehot0(row_outputs))
    else $error("more than one row selected");
  a_row_interlace: assert property ($changed(row_outputs) &&
    $past(row_outputs) != 34'h0 && row_outputs != 34'h0 |->
    row_outputs == ($past(row_outputs) << 2) || row_outputs == 34'h2 ||
    row_outputs == 34'h1)
    else $error("row order not interlaced");
  a_row_gap: assert property ($changed(row_outputs) &&
    $past(row_outputs) != 34'h0 && row_outputs != 34'h0 |-> gap >= MIN_GAP)
    else $error("row changed too early");
  a_cols_follow: assert property ($changed(column_outputs) |->
    $changed(row_outputs))
    else $error("columns changed without row step");
  // main scenarios reached
  c_ack: cover property ($rose(ack_output_pin_oe));
  c_icon_row: cover property (row_outputs[33]);
  c_pd_exit: cover property ($fell(cfg_out.power_down_bit));
endmodule : glm_chk
bind glm_driver glm_chk i_chk (
  .sys_clk(sys_clk), .rst(rst), .ack_output_pin(ack_output_pin),
  .ack_output_pin_oe(ack_output_pin_oe), .cfg_out(cfg_out),
  .row_outputs(row_outputs), .column_outputs(column_outputs)
);
`default_nettype wire

/* File: glm_host.sv */
// glm_host.sv: bus master model driving the serial clock and data pins
// assumes: bench resolves the data line with a pull-up; phases of 4+ cycles
`default_nettype none
module glm_host (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // wait n falling edges
  task automatic hw(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hw
  task automatic start();
    sda_drv = 1'b0;
    hw(8);
    scl = 1'b0;
    hw(4);
  endtask : start
  // stop with data rising while clock high
  task automatic stop();
    sda_drv = 1'b0;
    hw(4);
    scl = 1'b1;
    hw(8);
    sda_drv = 1'b1;
    hw(8);
  endtask : stop
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      hw(4);
      scl = 1'b1;
      hw(8);
      scl = 1'b0;
      hw(4);
    end
    sda_drv = 1'b1;
    hw(4);
    scl = 1'b1;
    hw(4);
    ack = ~sda_line;
    hw(4);
    scl = 1'b0;
    hw(4);
  endtask : put
endmodule : glm_host
`default_nettype wire

/* File: glm_driver_bench.sv */
// glm_driver_bench.sv: self-checking bench for the matrix driver core
// assumes: glm_host drives the bus; ack pin tied to data, pull-up on it
`include "glm_cfg.svh"
`default_nettype none
module glm_driver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 strap = 1'b1;
  logic                 ext_rst = 1'b0;
  logic                 por = 1'b0;
  logic                 ext_clk = 1'b0;
  logic [33:0]          snap;
  wire logic            scl, sda_drv, sda_line, ack, ack_oe;
  glm_pkg::glm_cfg_t    cfg, e;
  logic [33:0]          rows;
  logic [`GLM_COLS-1:0] cols;
  logic                 got;
  int                   n_fail = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  logic [7:0]           muxc [3] = '{8'h00, 8'h02, 8'h01};
  int                   nrow [3] = '{17, 26, 34};
  always #20 sys_clk = ~sys_clk;
  // open-drain data line
  assign sda_line = sda_drv & ~(ack_oe & ~ack);
  glm_host i_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  glm_driver #(.OSC_DIV(16'h0090), .EXT_IDLE(16'h012c)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .scl_in(scl), .sda_in(sda_line),
    .reset_source_strap(strap), .external_reset_input(ext_rst), .por_detect(por),
    .clock_source_input(ext_clk), .ack_output_pin(ack), .ack_output_pin_oe(ack_oe),
    .cfg_out(cfg), .row_outputs(rows), .column_outputs(cols)
  );
  // ****
  // compare and access tasks
  // ****
  task automatic cmp_cfg(input glm_pkg::glm_cfg_t g, input glm_pkg::glm_cfg_t x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask : cmp_cfg
  task automatic cmp_vec(input logic [33:0] g, input logic [33:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask : cmp_vec
  // one write transfer, every byte acked or none
  task automatic xfer(input logic [7:0] q[$], input logic ok);
    i_host.start();
    foreach (q[i]) begin
      i_host.put(q[i], got);
      cmp_vec({33'h0, got}, {33'h0, ok});
    end
    i_host.stop();
  endtask : xfer
  // wait for row r to be selected
  task automatic show(input int r);
    int k;
    k = 0;
    while (rows !== (34'h1 << r) && k < 6000) begin
      @(negedge sys_clk);
      k++;
    end
    cmp_vec(rows, 34'h1 << r);
  endtask : show
  // follow one frame of n rows
  task automatic frame(input int n);
    logic [33:0] last;
    int          r;
    int          k;
    show(0);
    for (int i = 1; i < n; i++) begin
      last = rows;
      k = 0;
      while (rows === last && k < 200) begin
        @(negedge sys_clk);
        k++;
      end
      r = (i < (n + 1) / 2) ? 2 * i : 2 * (i - (n + 1) / 2) + 1;
      cmp_vec(rows, 34'h1 << r);
    end
  endtask : frame
  task automatic pulse(input logic p);
    if (p)
      por = 1'b1;
    else
      ext_rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    por = 1'b0;
    ext_rst = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask : pulse
  // one period of the external clock, 200 cycles, rising edge first
  task automatic ext_period();
    ext_clk = 1'b1;
    repeat (100) @(negedge sys_clk);
    ext_clk = 1'b0;
    repeat (100) @(negedge sys_clk);
  endtask : ext_period
  task automatic final_report();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // ****
  // tests
  // ****
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    e = 16'h8000;
    cmp_cfg(cfg, e);
    cmp_vec(rows, 34'h0);
    // settings written while powered down
    xfer('{8'h78, 8'h00, 8'h0c, 8'h05, 8'h13, 8'h62, 8'h37}, 1'b1);
    e.disp_d = 1'b1;
    e.mux = 2'h1;
    e.bias = 3'h3;
    e.temp = 3'h2;
    e.multiplier_enable_bit = 1'b1;
    for (int f = 0; f < 4; f++) begin
      xfer('{8'h78, 8'h00, 8'h34 | 8'(f)}, 1'b1);
      e.mult_factor = 2'(f);
      cmp_cfg(cfg, e);
    end
    // read direction and foreign address refused
    xfer('{8'h79, 8'h20}, 1'b0);
    xfer('{8'h7a, 8'h00, 8'h20}, 1'b0);
    cmp_cfg(cfg, e);
    // memory writes, horizontal then vertical then icons
    xfer('{8'h78, 8'h00, 8'h20, 8'h40, 8'h80}, 1'b1);
    xfer('{8'h78, 8'h40, 8'h55, 8'haa}, 1'b1);
    xfer('{8'h78, 8'h00, 8'h22, 8'h82}, 1'b1);
    xfer('{8'h78, 8'h40, 8'hf0, 8'h0f}, 1'b1);
    xfer('{8'h78, 8'h00, 8'h45, 8'h87}, 1'b1);
    xfer('{8'h78, 8'h40, 8'h10, 8'hef}, 1'b1);
    for (int m = 0; m < 3; m++) begin
      xfer('{8'h78, 8'h00, 8'h04 | muxc[m]}, 1'b1);
      frame(nrow[m]);
    end
    show(0);
    cmp_vec(34'(cols[2:0]), 34'h1);
    show(1);
    cmp_vec(34'(cols[2:0]), 34'h2);
    show(8);
    cmp_vec(34'(cols[2]), 34'h1);
    show(33);
    cmp_vec(34'(cols[8:7]), 34'h1);
    // first external edge arms the source, the second one steps a row
    ext_period();
    snap = rows;
    ext_clk = 1'b1;
    repeat (3) @(negedge sys_clk);
    cmp_vec(rows, snap);
    @(negedge sys_clk);
    cmp_vec({33'h0, rows !== snap}, 34'h1);
    // divider stays ignored until the external clock has been idle long enough
    snap = rows;
    repeat (100) @(negedge sys_clk);
    ext_clk = 1'b0;
    repeat (150) @(negedge sys_clk);
    cmp_vec(rows, snap);
    repeat (300) @(negedge sys_clk);
    cmp_vec({33'h0, rows !== snap}, 34'h1);
    // reset source chosen by strap
    strap = 1'b0;
    pulse(1'b1);
    e.power_down_bit = 1'b0;
    e.vertical = 1'b1;
    cmp_cfg(cfg, e);
    pulse(1'b0);
    e = 16'h8000;
    cmp_cfg(cfg, e);
    cmp_vec(rows, 34'h0);
    strap = 1'b1;
    xfer('{8'h78, 8'h00, 8'h20}, 1'b1);
    pulse(1'b1);
    cmp_cfg(cfg, e);
    final_report();
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      final_report();
    end
  end
endmodule : glm_driver_bench
`default_nettype wire
